// ==== common/adc_regs_pkg.sv ====
// Purpose: constants and carrier types for the converter register block
// Assumes: AXI4-Lite, 32-bit data, one aligned word per register
// Notes:   printed offsets are not multiples of four; byte address is four times index
package adc_regs_pkg;
   localparam int          AW               = 12;
   localparam logic [11:0] IDX_CTL0         = 12'hF70;
   localparam logic [11:0] IDX_CTL1         = 12'hF71;
   localparam logic [11:0] IDX_RES_HI       = 12'hF72;
   localparam logic [11:0] IDX_RES_LO       = 12'hF73;
   localparam logic [11:0] IDX_HI_LIM       = 12'hF74;
   localparam logic [11:0] IDX_LO_LIM       = 12'hF76;
   // control register 0 fields
   localparam int          CTL0_GO          = 7;
   localparam int          CTL0_REF_LOW     = 6;
   localparam int          CTL0_REF_OUT     = 5;
   localparam int          CTL0_REPEAT      = 4;
   // control/status register 1 fields
   localparam int          CTL1_REF_HIGH    = 7;
   localparam int          CTL1_HI_FLAG     = 6;
   localparam int          CTL1_LO_FLAG     = 5;
   localparam int          CTL1_HI_EN       = 4;
   localparam int          CTL1_LO_EN       = 3;
   localparam logic [7:0]  CTL0_RESET       = 8'h00;
   localparam logic [7:0]  HI_LIM_RESET     = 8'hFF;
   localparam logic [7:0]  LO_LIM_RESET     = 8'h00;
   localparam logic        REF_HIGH_RESET   = 1'b1;
   // buffer modes
   localparam logic [2:0]  BUF_SE_RAW       = 3'h0;
   localparam logic [2:0]  BUF_SE_UNITY     = 3'h1;
   localparam logic [2:0]  BUF_DIFF_RAW     = 3'h4;
   localparam logic [2:0]  BUF_DIFF_UNITY   = 3'h5;
   // channel codes
   localparam logic [3:0]  CH_SE_TEMP       = 4'hE;
   localparam logic [3:0]  CH_DIFF_LAST     = 4'hA;
   localparam logic [3:0]  CH_DIFF_CAL      = 4'hF;
   // reference levels
   localparam logic [1:0]  REF_EXTERNAL     = 2'h0;
   localparam logic [1:0]  REF_1V0          = 2'h1;
   localparam logic [1:0]  REF_2V0          = 2'h2;
   // timing in system clocks at 100 MHz
   localparam int          CLK_MHZ          = 100;
   localparam int          FIRST_CLKS       = 5129;
   localparam int          REPEAT_CLKS      = 256;
   localparam int          CNT_W            = 14;
   localparam logic [1:0]  RESP_OKAY        = 2'h0;
   localparam logic [1:0]  RESP_SLVERR      = 2'h2;

   typedef enum logic [1:0] {
      REF_SEL_EXT  = 2'b00,
      REF_SEL_1V0  = 2'b01,
      REF_SEL_2V0  = 2'b10,
      REF_SEL_RSVD = 2'b11
   } ref_sel_t;

   // converter core steering
   typedef struct packed {
      logic       run;
      logic       diff;
      logic       buffered;
      logic       offset_cal;
      logic       inputs_off;
      logic [2:0] pos_pin;
      logic [2:0] neg_pin;
      logic [3:0] se_chan;
      ref_sel_t   ref_sel;
      logic       ref_out;
   } core_ctl_t;

   // converter core result
   typedef struct packed {
      logic        done;
      logic [12:0] value;
      logic        overflow;
   } core_res_t;
endpackage

// ==== logic/adc_register_alarm_interface.sv ====
// Purpose: register, result and threshold-alarm logic for an on-chip converter
// Assumes: analog core pulses done with each sample; AXI4-Lite slave, one access at a time
// Notes:   byte address is four times the register index
// What this block does
// - differential channel codes 0000-1010 select fixed positive/negative pin pairs
// - differential code 1111 is offset calibration; 1011-1110 reserved, inputs off
// - reference {high,low}: ext, 1.0 V, 2.0 V, reserved; high bit resets 1
// - high alarm flag set by hardware only, cleared by writing 1
// - low alarm flag set by hardware only, cleared by writing 1
// - high alarm enable gates interrupt; flag sets regardless
// - low alarm enable gates interrupt; flag sets regardless
// - buffer mode codes 000,001,100,101 valid; others reserved
// - result is 13-bit two's complement; upper eight bits in high byte
// - low register: five low bits on top, overflow at bit 0
// - reading high byte latches matching low bits for coherent read
// - result invalid during single shot; continuous holds latest sample
// - result registers read-only; contents undefined until first conversion
// - overflow flag reads 1 when sample overflowed, else 0
// - high alarm when upper eight result bits exceed high limit, reset FF
// - low alarm when upper eight result bits fall below low limit, reset 0
// - alarms inactive in differential modes
// - writing 1 to go bit starts or restarts; cleared on completion
// - single shot 5129 clocks; repeat every 256 after; temperature doubles
// - channel field meaning depends on single-ended or differential mode
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
module adc_register_alarm_interface (
   input  wire logic                         i_clk,
   input  wire logic                         i_sys_rst,
   input  wire logic [adc_regs_pkg::AW+1:0]  i_awaddr,
   input  wire logic                         i_awvalid,
   output logic                              o_awready,
   input  wire logic [31:0]                  i_wdata,
   input  wire logic [3:0]                   i_wstrb,
   input  wire logic                         i_wvalid,
   output logic                              o_wready,
   output logic [1:0]                        o_bresp,
   output logic                              o_bvalid,
   input  wire logic                         i_bready,
   input  wire logic [adc_regs_pkg::AW+1:0]  i_araddr,
   input  wire logic                         i_arvalid,
   output logic                              o_arready,
   output logic [31:0]                       o_rdata,
   output logic [1:0]                        o_rresp,
   output logic                              o_rvalid,
   input  wire logic                         i_rready,
   input  wire adc_regs_pkg::core_res_t      i_core_res,
   output adc_regs_pkg::core_ctl_t           o_core_ctl,
   output logic                              o_irq
);
   import adc_regs_pkg::*;

   typedef enum logic [1:0] {
      CV_IDLE  = 2'b00,
      CV_FIRST = 2'b01,
      CV_RUN   = 2'b10
   } conv_state_t;

   // registers
   logic [7:0]        ctl0_reg;
   logic              ref_high_reg;
   logic              hi_flag_reg;
   logic              lo_flag_reg;
   logic              hi_en_reg;
   logic              lo_en_reg;
   logic [2:0]        buf_mode_reg;
   logic [7:0]        hi_lim_reg;
   logic [7:0]        lo_lim_reg;
   logic [12:0]       result_reg;
   logic              ovf_reg;
   logic [4:0]        low_latch_reg;
   logic              ovf_latch_reg;
   conv_state_t       state_reg;
   conv_state_t       state_next;
   logic [CNT_W-1:0]  cnt_reg;
   logic [CNT_W-1:0]  cnt_next;
   core_ctl_t         core_ctl_reg;
   logic              irq_reg;

   // bus registers
   logic              aw_held_reg;
   logic [AW-1:0]     aw_idx_reg;
   logic              w_held_reg;
   logic [31:0]       wdata_reg;
   logic [3:0]        wstrb_reg;
   logic              bvalid_reg;
   logic [1:0]        bresp_reg;
   logic              rvalid_reg;
   logic [31:0]       rdata_reg;
   logic [1:0]        rresp_reg;

   // --- bus decode ---
   wire               aw_take  = i_awvalid && !aw_held_reg && !bvalid_reg;
   wire               w_take   = i_wvalid && !w_held_reg && !bvalid_reg;
   wire               wr_fire  = aw_held_reg && w_held_reg && !bvalid_reg;
   wire               lane0    = wstrb_reg[0];
   wire               wr_ctl0  = wr_fire && lane0 && (aw_idx_reg == IDX_CTL0);
   wire               wr_ctl1  = wr_fire && lane0 && (aw_idx_reg == IDX_CTL1);
   wire               wr_hlim  = wr_fire && lane0 && (aw_idx_reg == IDX_HI_LIM);
   wire               wr_llim  = wr_fire && lane0 && (aw_idx_reg == IDX_LO_LIM);
   wire               wr_known = (aw_idx_reg == IDX_CTL0) || (aw_idx_reg == IDX_CTL1) ||
                                 (aw_idx_reg == IDX_RES_HI) || (aw_idx_reg == IDX_RES_LO) ||
                                 (aw_idx_reg == IDX_HI_LIM) || (aw_idx_reg == IDX_LO_LIM);
   wire [7:0]         wbyte    = wdata_reg[7:0];
   wire               ar_take  = i_arvalid && !rvalid_reg;
   wire [AW-1:0]      ar_idx   = i_araddr[AW+1:2];
   wire               rd_res_hi = ar_take && (ar_idx == IDX_RES_HI);

   // --- mode decode ---
   wire               diff_mode = buf_mode_reg[2];
   wire               buf_ok    = (buf_mode_reg == BUF_SE_RAW) || (buf_mode_reg == BUF_SE_UNITY) ||
                                  (buf_mode_reg == BUF_DIFF_RAW) ||
                                  (buf_mode_reg == BUF_DIFF_UNITY);
   wire [3:0]         chan      = ctl0_reg[3:0];
   wire               temp_sel  = !diff_mode && (chan == CH_SE_TEMP);
   wire               diff_cal  = diff_mode && (chan == CH_DIFF_CAL);
   wire               diff_ok   = diff_mode && (chan <= CH_DIFF_LAST);
   logic [2:0]        pos_pin;
   logic [2:0]        neg_pin;

   // differential pair table
   always_comb begin
      pos_pin = 3'h0;
      neg_pin = 3'h0;
      case (chan)
         4'h0: begin pos_pin = 3'h0; neg_pin = 3'h1; end
         4'h1: begin pos_pin = 3'h2; neg_pin = 3'h3; end
         4'h2: begin pos_pin = 3'h4; neg_pin = 3'h5; end
         4'h3: begin pos_pin = 3'h1; neg_pin = 3'h0; end
         4'h4: begin pos_pin = 3'h3; neg_pin = 3'h2; end
         4'h5: begin pos_pin = 3'h5; neg_pin = 3'h4; end
         4'h6: begin pos_pin = 3'h6; neg_pin = 3'h5; end
         4'h7: begin pos_pin = 3'h0; neg_pin = 3'h2; end
         4'h8: begin pos_pin = 3'h0; neg_pin = 3'h3; end
         4'h9: begin pos_pin = 3'h0; neg_pin = 3'h4; end
         4'hA: begin pos_pin = 3'h0; neg_pin = 3'h5; end
         default: begin pos_pin = 3'h0; neg_pin = 3'h0; end
      endcase
   end

   // --- conversion sequencing ---
   localparam logic [CNT_W-1:0] FIRST_N  = CNT_W'(FIRST_CLKS);
   localparam logic [CNT_W-1:0] REPEAT_N = CNT_W'(REPEAT_CLKS);
   wire               go_write  = wr_ctl0 && wbyte[CTL0_GO];
   wire               temp_go   = !diff_mode && (wbyte[3:0] == CH_SE_TEMP);
   wire [CNT_W-1:0]   first_len = temp_go ? CNT_W'(2 * FIRST_CLKS) : FIRST_N;
   wire [CNT_W-1:0]   rep_len   = temp_sel ? CNT_W'(2 * REPEAT_CLKS) : REPEAT_N;
   wire               running   = (state_reg != CV_IDLE);
   wire               cnt_end   = running && (cnt_reg == CNT_W'(1));
   // count end marks completion; the core's done pulse in that same cycle carries the value
   wire               sample    = running && cnt_end;
   wire               repeat_on = ctl0_reg[CTL0_REPEAT];

   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      if (go_write) begin
         state_next = CV_FIRST;
         cnt_next   = first_len;
      end else begin
         case (state_reg)
            CV_IDLE: begin
               cnt_next = cnt_reg;
            end
            CV_FIRST, CV_RUN: begin
               if (!cnt_end) begin
                  cnt_next = cnt_reg - CNT_W'(1);
               end else if (repeat_on) begin
                  state_next = CV_RUN;
                  cnt_next   = rep_len;
               end else begin
                  state_next = CV_IDLE;
                  cnt_next   = '0;
               end
            end
            default: begin
               state_next = CV_IDLE;
               cnt_next   = '0;
            end
         endcase
      end
   end

   // --- alarms ---
   wire [7:0]         new_top  = i_core_res.value[12:5];
   wire               store    = sample && i_core_res.done;
   wire               alarm_ok = store && !diff_mode;
   wire               hi_hit   = alarm_ok && $signed(new_top) > $signed(hi_lim_reg);
   wire               lo_hit   = alarm_ok && $signed(new_top) < $signed(lo_lim_reg);
   // set beats a simultaneous write-one clear
   wire               hi_flag_next = hi_hit || (hi_flag_reg && !(wr_ctl1 && wbyte[CTL1_HI_FLAG]));
   wire               lo_flag_next = lo_hit || (lo_flag_reg && !(wr_ctl1 && wbyte[CTL1_LO_FLAG]));
   wire               hi_en_next   = wr_ctl1 ? wbyte[CTL1_HI_EN] : hi_en_reg;
   wire               lo_en_next   = wr_ctl1 ? wbyte[CTL1_LO_EN] : lo_en_reg;
   wire               irq_next     = (hi_flag_next && hi_en_next) ||
                                     (lo_flag_next && lo_en_next);

   // go bit reads 1 until the single-shot ends or a repeat run is stopped
   wire               go_bit   = running;
   wire [7:0]         ctl0_rd  = {go_bit, ctl0_reg[6:0]};
   wire [7:0]         ctl1_rd  = {ref_high_reg, hi_flag_reg, lo_flag_reg, hi_en_reg, lo_en_reg,
                                  buf_mode_reg};
   wire               in_single = running && !repeat_on;
   // high read launches latch; low read shows the latch, reserved bits read zero
   wire [7:0]         res_hi_rd = in_single ? 8'h00 : result_reg[12:5];
   wire [7:0]         res_lo_rd = {low_latch_reg, 2'b00, ovf_latch_reg};
   logic [7:0]        rd_byte;
   logic              rd_known;

   always_comb begin
      rd_byte  = 8'h00;
      rd_known = 1'b1;
      case (ar_idx)
         IDX_CTL0:   rd_byte = ctl0_rd;
         IDX_CTL1:   rd_byte = ctl1_rd;
         IDX_RES_HI: rd_byte = res_hi_rd;
         IDX_RES_LO: rd_byte = res_lo_rd;
         IDX_HI_LIM: rd_byte = hi_lim_reg;
         IDX_LO_LIM: rd_byte = lo_lim_reg;
         default:    rd_known = 1'b0;
      endcase
   end

   wire core_bad = (!buf_ok) || (diff_mode && !diff_ok && !diff_cal);
   core_ctl_t core_ctl_next;
   always_comb begin
      core_ctl_next            = '0;
      core_ctl_next.run        = (state_next != CV_IDLE);
      core_ctl_next.diff       = diff_mode;
      core_ctl_next.buffered   = buf_mode_reg[0];
      core_ctl_next.offset_cal = diff_cal;
      core_ctl_next.inputs_off = core_bad;
      core_ctl_next.pos_pin    = pos_pin;
      core_ctl_next.neg_pin    = neg_pin;
      core_ctl_next.se_chan    = chan;
      core_ctl_next.ref_sel    = ref_sel_t'({ref_high_reg, ctl0_reg[CTL0_REF_LOW]});
      core_ctl_next.ref_out    = ctl0_reg[CTL0_REF_OUT];
   end

   // --- registers ---
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ctl0_reg     <= CTL0_RESET;
         ref_high_reg <= REF_HIGH_RESET;
         hi_flag_reg  <= 1'b0;
         lo_flag_reg  <= 1'b0;
         hi_en_reg    <= 1'b0;
         lo_en_reg    <= 1'b0;
         buf_mode_reg <= BUF_SE_RAW;
         hi_lim_reg   <= HI_LIM_RESET;
         lo_lim_reg   <= LO_LIM_RESET;
         state_reg    <= CV_IDLE;
         cnt_reg      <= '0;
         core_ctl_reg <= '0;
         irq_reg      <= 1'b0;
      end else begin
         if (wr_ctl0) begin
            ctl0_reg <= {1'b0, wbyte[6:0]};
         end
         if (wr_ctl1) begin
            ref_high_reg <= wbyte[CTL1_REF_HIGH];
            buf_mode_reg <= wbyte[2:0];
         end
         hi_flag_reg  <= hi_flag_next;
         lo_flag_reg  <= lo_flag_next;
         hi_en_reg    <= hi_en_next;
         lo_en_reg    <= lo_en_next;
         if (wr_hlim) begin
            hi_lim_reg <= wbyte;
         end
         if (wr_llim) begin
            lo_lim_reg <= wbyte;
         end
         state_reg    <= state_next;
         cnt_reg      <= cnt_next;
         core_ctl_reg <= core_ctl_next;
         irq_reg      <= irq_next;
      end
   end

   // result storage has no reset: undefined until the first sample
   always_ff @(posedge i_clk) begin
      if (store) begin
         result_reg <= i_core_res.value;
         ovf_reg    <= i_core_res.overflow;
      end
      if (rd_res_hi) begin
         low_latch_reg <= result_reg[4:0];
         ovf_latch_reg <= ovf_reg;
      end
   end

   // --- AXI4-Lite slave ---
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         aw_held_reg <= 1'b0;
         aw_idx_reg  <= '0;
         w_held_reg  <= 1'b0;
         wdata_reg   <= '0;
         wstrb_reg   <= '0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= RESP_OKAY;
         rvalid_reg  <= 1'b0;
         rdata_reg   <= '0;
         rresp_reg   <= RESP_OKAY;
      end else begin
         if (aw_take) begin
            aw_held_reg <= 1'b1;
            aw_idx_reg  <= i_awaddr[AW+1:2];
         end
         if (w_take) begin
            w_held_reg <= 1'b1;
            wdata_reg  <= i_wdata;
            wstrb_reg  <= i_wstrb;
         end
         if (wr_fire) begin
            // result registers accept the write silently
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            bvalid_reg  <= 1'b1;
            bresp_reg   <= wr_known ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid_reg && i_bready) begin
            bvalid_reg <= 1'b0;
         end
         if (ar_take) begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= {24'h000000, rd_byte};
            rresp_reg  <= rd_known ? RESP_OKAY : RESP_SLVERR;
         end else if (rvalid_reg && i_rready) begin
            rvalid_reg <= 1'b0;
         end
      end
   end

   assign o_awready  = !aw_held_reg && !bvalid_reg;
   assign o_wready   = !w_held_reg && !bvalid_reg;
   assign o_bvalid   = bvalid_reg;
   assign o_bresp    = bresp_reg;
   assign o_arready  = !rvalid_reg;
   assign o_rvalid   = rvalid_reg;
   assign o_rdata    = rdata_reg;
   assign o_rresp    = rresp_reg;
   assign o_core_ctl = core_ctl_reg;
   assign o_irq      = irq_reg;
endmodule

// ==== testbench/adc_register_alarm_interface_props.sv ====
// Purpose: bus handshake and alarm checks on the converter register block
// Assumes: one clock, async active-high reset
// Notes:   sees top-level ports only
`timescale 1ns/1ps
module adc_register_alarm_interface_props (
   input wire logic                    i_clk,
   input wire logic                    i_sys_rst,
   input wire logic                    i_arvalid,
   input wire logic                    o_arready,
   input wire logic                    o_awready,
   input wire logic                    o_wready,
   input wire logic                    o_bvalid,
   input wire logic                    i_bready,
   input wire logic [1:0]              o_bresp,
   input wire logic                    o_rvalid,
   input wire logic                    i_rready,
   input wire logic [31:0]             o_rdata,
   input wire logic [1:0]              o_rresp,
   input wire adc_regs_pkg::core_res_t i_core_res,
   input wire adc_regs_pkg::core_ctl_t o_core_ctl,
   input wire logic                    o_irq
);
   import adc_regs_pkg::*;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   sequence s_ar_taken;
      i_arvalid && o_arready;
   endsequence
   sequence s_sw_write;
      o_bvalid || $past(o_bvalid) || $past(o_bvalid, 2);
   endsequence
   a_read_answer: assert property (s_ar_taken |=> o_rvalid)
      else $error("read not answered next cycle");
   a_read_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
      else $error("read data dropped before rready");
   a_write_hold: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
      else $error("write response dropped before bready");
   a_ready_block: assert property (o_bvalid |-> !o_awready && !o_wready)
      else $error("write channel ready during pending response");
   a_slverr_zero: assert property (o_rvalid && o_rresp == RESP_SLVERR |-> o_rdata == 32'h0)
      else $error("error read returned data");
   a_byte_lane: assert property (o_rvalid |-> o_rdata[31:8] == 24'h0)
      else $error("upper read bits not zero");
   a_cal_diff: assert property (o_core_ctl.offset_cal |-> o_core_ctl.diff)
      else $error("offset calibration outside differential mode");
   a_irq_cause: assert property ($rose(o_irq) |-> $past(i_core_res.done) ||
      $past(i_core_res.done, 2) || o_bvalid)
      else $error("irq rose without sample or write");
   a_irq_clear: assert property ($fell(o_irq) |-> s_sw_write)
      else $error("irq fell without software write");
endmodule

// ==== testbench/adc_core_model.sv ====
// Purpose: behavioural analog converter core
// Assumes: converts while run is high, done held for the whole conversion
// Notes:   idle outputs show inverted data so stale samples never look valid
`timescale 1ns/1ps
module adc_core_model (
   input  wire adc_regs_pkg::core_ctl_t i_ctl,
   input  wire logic [12:0]             i_value,
   input  wire logic                    i_ovf,
   output adc_regs_pkg::core_res_t      o_res
);
   import adc_regs_pkg::*;
   assign o_res.done     = i_ctl.run;
   assign o_res.value    = i_ctl.run ? i_value : ~i_value;
   assign o_res.overflow = i_ctl.run ? i_ovf : ~i_ovf;
endmodule

// ==== testbench/test_adc_register_alarm_interface.sv ====
// Purpose: self-checking bench for the converter register block
// Assumes: AXI4-Lite master tasks, behavioural core
// Notes:   ready sampled at the falling edge, changed after the rising edge
`timescale 1ns/1ps
module test_adc_register_alarm_interface;
   import adc_regs_pkg::*;
   logic i_clk, i_sys_rst, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, ovf;
   logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq;
   logic [13:0] i_awaddr, i_araddr;
   logic [31:0] i_wdata, o_rdata;
   logic [3:0]  i_wstrb;
   logic [1:0]  o_bresp, o_rresp, rr;
   logic [12:0] value;
   logic [7:0]  rd;
   core_res_t   i_core_res;
   core_ctl_t   o_core_ctl;
   int          miscompares, num_checks;
   localparam logic [2:0] POS [11] = '{3'h0,3'h2,3'h4,3'h1,3'h3,3'h5,3'h6,3'h0,3'h0,3'h0,3'h0};
   localparam logic [2:0] NEG [11] = '{3'h1,3'h3,3'h5,3'h0,3'h2,3'h4,3'h5,3'h2,3'h3,3'h4,3'h5};
   localparam logic [2:0] MODES [4] = '{3'h0, 3'h1, 3'h4, 3'h5};
   localparam logic [1:0] REFS [4] = '{2'h0, 2'h1, 2'h2, 2'h2};
   always #5 i_clk = ~i_clk;
   adc_register_alarm_interface uut (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
      .i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(o_awready), .i_wdata(i_wdata),
      .i_wstrb(i_wstrb), .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bresp(o_bresp),
      .o_bvalid(o_bvalid), .i_bready(i_bready), .i_araddr(i_araddr), .i_arvalid(i_arvalid),
      .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid),
      .i_rready(i_rready), .i_core_res(i_core_res), .o_core_ctl(o_core_ctl), .o_irq(o_irq));
   adc_core_model u_core (.i_ctl(o_core_ctl), .i_value(value), .i_ovf(ovf), .o_res(i_core_res));
   task automatic end_sim();
      if (miscompares == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("FAIL %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic axi_write(input logic [11:0] idx, input logic [7:0] d);
      logic aw, w, a, b;
      i_awaddr <= {idx, 2'h0};
      i_wdata <= {24'h0, d};
      i_awvalid <= 1'b1;
      i_wvalid <= 1'b1;
      aw = 1'b1;
      w = 1'b1;
      while (aw || w) begin
         @(negedge i_clk);
         a = o_awready;
         b = o_wready;
         @(posedge i_clk);
         if (a) i_awvalid <= 1'b0;
         if (b) i_wvalid <= 1'b0;
         aw = aw && !a;
         w = w && !b;
      end
      // bready rises in the same cycle as bvalid, so the response does not wait
      @(posedge i_clk);
      i_bready <= 1'b1;
      do begin
         @(negedge i_clk);
         a = o_bvalid;
         @(posedge i_clk);
      end while (!a);
      i_bready <= 1'b0;
   endtask
   task automatic axi_read(input logic [11:0] idx, output logic [7:0] d, output logic [1:0] r);
      logic a;
      i_araddr <= {idx, 2'h0};
      i_arvalid <= 1'b1;
      do begin
         @(negedge i_clk);
         a = o_arready;
         @(posedge i_clk);
      end while (!a);
      i_arvalid <= 1'b0;
      @(posedge i_clk);
      i_rready <= 1'b1;
      do begin
         @(negedge i_clk);
         a = o_rvalid;
         d = o_rdata[7:0];
         r = o_rresp;
         @(posedge i_clk);
      end while (!a);
      i_rready <= 1'b0;
   endtask
   task automatic rd_chk(input string n, input logic [11:0] idx, input logic [7:0] exp);
      axi_read(idx, rd, rr);
      check(n, {24'h0, rd}, {24'h0, exp});
   endtask
   task automatic run_conv(input logic [7:0] c0, input int clks);
      int n;
      axi_write(IDX_CTL0, c0);
      n = 0;
      do begin
         @(negedge i_clk);
         n++;
      end while ((n < 3 || o_core_ctl.run === 1'b1) && n < 20000);
      repeat (2) @(posedge i_clk);
      check("conv_clks", {31'h0, n == clks}, 32'h1);
   endtask
   task automatic t_reset();
      rd_chk("ctl0_rst", IDX_CTL0, 8'h00);
      rd_chk("ctl1_rst", IDX_CTL1, 8'h80);
      rd_chk("hi_rst", IDX_HI_LIM, 8'hFF);
      rd_chk("lo_rst", IDX_LO_LIM, 8'h00);
      check("ref_rst", {30'h0, o_core_ctl.ref_sel}, {30'h0, REF_2V0});
      rd_chk("unmapped", 12'hF75, 8'h00);
      check("unmapped_resp", {30'h0, rr}, {30'h0, RESP_SLVERR});
   endtask
   task automatic t_map();
      axi_write(IDX_CTL1, 8'h85);
      for (int i = 0; i < 16; i++) begin
         axi_write(IDX_CTL0, 8'(i));
         repeat (2) @(negedge i_clk);
         if (i <= 10) begin
            check("pos_pin", o_core_ctl.pos_pin, POS[i]);
            check("neg_pin", o_core_ctl.neg_pin, NEG[i]);
         end
         if (i > 10 && i < 15) check("inputs_off", o_core_ctl.inputs_off, 1'b1);
         check("cal", o_core_ctl.offset_cal, i == 15);
         check("diff", o_core_ctl.diff, 1'b1);
         @(posedge i_clk);
      end
      for (int k = 0; k < 4; k++) begin
         axi_write(IDX_CTL1, {REFS[k][1], 4'h0, MODES[k]});
         axi_write(IDX_CTL0, {1'b0, REFS[k][0], 2'h0, 4'(k)});
         repeat (2) @(negedge i_clk);
         check("mode_diff", o_core_ctl.diff, MODES[k][2]);
         check("mode_buf", o_core_ctl.buffered, MODES[k][0]);
         check("ref_sel", {30'h0, o_core_ctl.ref_sel}, {30'h0, REFS[k]});
         if (!MODES[k][2]) check("se_chan", o_core_ctl.se_chan, 4'(k));
         @(posedge i_clk);
      end
   endtask
   task automatic t_high();
      value <= 13'h0413;
      ovf <= 1'b1;
      axi_write(IDX_HI_LIM, 8'h10);
      axi_write(IDX_CTL1, 8'h90);
      run_conv(8'h80, FIRST_CLKS);
      rd_chk("go_clear", IDX_CTL0, 8'h00);
      rd_chk("hi_flag", IDX_CTL1, 8'hD0);
      check("irq_hi", o_irq, 1'b1);
      rd_chk("res_hi", IDX_RES_HI, 8'h20);
      rd_chk("res_lo", IDX_RES_LO, 8'h99);
      axi_write(IDX_RES_HI, 8'h55);
      rd_chk("res_ro", IDX_RES_HI, 8'h20);
      axi_write(IDX_CTL1, 8'h90);
      rd_chk("w0_keep", IDX_CTL1, 8'hD0);
      axi_write(IDX_CTL1, 8'hD0);
      rd_chk("w1_clear", IDX_CTL1, 8'h90);
      check("irq_drop", o_irq, 1'b0);
   endtask
   task automatic t_low();
      value <= 13'h1F00;
      ovf <= 1'b0;
      axi_write(IDX_LO_LIM, 8'h10);
      axi_write(IDX_HI_LIM, 8'h7F);
      axi_write(IDX_CTL1, 8'h80);
      run_conv(8'h80, FIRST_CLKS);
      rd_chk("lo_flag", IDX_CTL1, 8'hA0);
      check("irq_masked", o_irq, 1'b0);
      rd_chk("res_hi_neg", IDX_RES_HI, 8'hF8);
      rd_chk("res_lo_ovf", IDX_RES_LO, 8'h00);
      axi_write(IDX_CTL1, 8'h88);
      rd_chk("lo_en", IDX_CTL1, 8'hA8);
      check("irq_lo", o_irq, 1'b1);
      axi_write(IDX_CTL1, 8'hA8);
   endtask
   task automatic t_diff();
      value <= 13'h0413;
      axi_write(IDX_HI_LIM, 8'h10);
      axi_write(IDX_CTL1, 8'h9D);
      run_conv(8'h80, FIRST_CLKS);
      rd_chk("diff_quiet", IDX_CTL1, 8'h9D);
      check("irq_diff", o_irq, 1'b0);
      axi_write(IDX_CTL1, 8'h81);
      // temperature channel takes twice as long
      run_conv(8'h8E, 2 * FIRST_CLKS);
      axi_write(IDX_CTL0, 8'h90);
      repeat (5300) @(posedge i_clk);
      value <= 13'h0300;
      rd_chk("repeat_conversion_bit_hold", IDX_RES_HI, 8'h20);
      repeat (90) @(posedge i_clk);
      rd_chk("repeat_conversion_bit_next", IDX_RES_HI, 8'h18);
   endtask
   initial begin
      i_clk = 1'b0;
      i_sys_rst = 1'b1;
      {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, ovf} = '0;
      {i_awaddr, i_araddr, i_wdata, value} = '0;
      i_wstrb = 4'hF;
      miscompares = 0;
      num_checks = 0;
      repeat (3) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      @(posedge i_clk);
      t_reset();
      t_map();
      t_high();
      t_low();
      t_diff();
      end_sim();
   end
   initial begin
      repeat (60000) @(posedge i_clk);
      miscompares++;
      end_sim();
   end
endmodule
bind adc_register_alarm_interface adc_register_alarm_interface_props u_props (
   .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_arvalid(i_arvalid), .o_arready(o_arready),
   .o_awready(o_awready), .o_wready(o_wready), .o_bvalid(o_bvalid), .i_bready(i_bready),
   .o_bresp(o_bresp), .o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata),
   .o_rresp(o_rresp), .i_core_res(i_core_res), .o_core_ctl(o_core_ctl), .o_irq(o_irq));
